// >>> hdl/mcbwp_pkg.sv
// constants for the command block write path of a pluggable module
// assumes a 100 MHz management clock and a byte-level two-wire engine
package mcbwp_pkg;
	localparam logic [7:0]  PAGE_ADVERT     = 8'h01;
	localparam logic [7:0]  PAGE_CMD        = 8'h9f;
	localparam logic [7:0]  PAGE_EPL_FIRST  = 8'ha0;
	localparam logic [7:0]  PAGE_EPL_LAST   = 8'haf;
	localparam logic [7:0]  ADDR_INST_ADV   = 8'ha3;
	localparam logic [7:0]  ADDR_MAX_WRITE  = 8'ha4;
	localparam logic [7:0]  ADDR_TRIG_NACK  = 8'ha5;
	localparam logic [7:0]  ADDR_NACK_IND   = 8'ha6;
	localparam logic [7:0]  ADDR_CMD_LO     = 8'h80;
	localparam logic [7:0]  ADDR_CMD_HI     = 8'h81;
	localparam logic [7:0]  ADDR_UPPER_LAST = 8'hff;
	localparam logic [11:0] BASE_WRITE_BYTES = 12'h008;
	localparam logic [7:0]  ADV_MAX_NO_PAGING = 8'h0f;
	localparam logic [7:0]  ADV_STEPS_PER_PAGE = 8'h10;
	localparam int          INST_MSB        = 7;
	localparam int          INST_LSB        = 6;
	localparam int          BGND_BIT        = 5;
	localparam int          AUTOPAGE_BIT    = 4;
	localparam int          PROC_OPT_BIT    = 7;
	localparam int          NACK_IND_BIT    = 7;
	localparam logic [1:0]  INST_NONE       = 2'h0;
	localparam logic [1:0]  INST_ONE        = 2'h1;
	localparam logic [1:0]  INST_TWO        = 2'h2;
	localparam logic [12:0] NACK_STEP_MS    = 13'h00a0;
	localparam logic [12:0] NACK_BASE_MS    = 13'h0050;
	localparam int          MS_NS           = 1000000;
	localparam int          CLK_PERIOD_NS   = 10;
	localparam int          CYCLES_PER_MS   = MS_NS / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WRITE,
		ST_CAPTURE,
		ST_EXECUTE
	} mcbwp_state_t;
endpackage

// >>> hdl/mcbwp_top.sv
// command block write path: write length, paging, trigger, refusal
// assumes a same-clock byte engine that decodes the two-wire bus
`timescale 1ns/1ps
//Contract
//- plain writes 8 bytes, longer only pages 9F-AF
//- command write limit is (advert+1) times eight
//- bytes beyond advertised limit are discarded
//- option bit picks stop or byte-129 trigger
//- command refusal time is field times 160 ms; here field 0 gives 80 ms
//- indicator selects general or command refusal time
//- general refusal time is 80 minus field
//- each instance owns one bank, same behaviour
//- no background: refuse until command completes
//- background: refuse only until command captured
//- flash writes never disturb foreground accesses; grant is held off only for host writes, not for advertisement reads
//- no paging: advertise at most 128 bytes
//- no paging advert with under two pages
//- auto paging wraps 255 to 128, next page
//- past last payload page wrap to A0h
//- advertised length matches implemented page bytes
//- instance field 00 none, 01 one, 10 two
//- page-count field encodes implemented payload pages
module mcbwp_top #(
	parameter logic [1:0] P_INSTANCES     = 2'h2,
	parameter logic       P_BACKGROUND    = 1'b1,
	parameter logic       P_AUTOPAGE      = 1'b1,
	parameter logic [3:0] P_EPL_CODE      = 4'h7,
	parameter logic [7:0] P_MAX_WRITE     = 8'hff,
	parameter logic       P_PROC_OPT      = 1'b1,
	parameter logic [4:0] P_CMD_NACK      = 5'h03,
	parameter logic       P_NACK_IND      = 1'b1,
	parameter logic [6:0] P_MAX_NACK      = 7'h00,
	parameter int         P_CYCLES_PER_MS = mcbwp_pkg::CYCLES_PER_MS
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        bus_start,
	input  wire logic [7:0]  bus_page,
	input  wire logic        bus_bank,
	input  wire logic [7:0]  bus_addr,
	input  wire logic        bus_byte_valid,
	input  wire logic [7:0]  bus_byte,
	input  wire logic        bus_stop,
	input  wire logic        rd_req,
	input  wire logic [7:0]  rd_page,
	input  wire logic [7:0]  rd_addr,
	input  wire logic        cmd_captured,
	input  wire logic        cmd_done,
	input  wire logic        cmd_done_bank,
	input  wire logic        flash_req,
	output logic             bus_nack_r,
	output logic             mem_we_r,
	output logic             mem_bank_r,
	output logic [7:0]       mem_page_r,
	output logic [7:0]       mem_addr_r,
	output logic [7:0]       mem_data_r,
	output logic             cmd_start_r,
	output logic             cmd_bank_r,
	output logic [7:0]       rd_data_r,
	output logic             rd_hit_r,
	output logic             flash_gnt_r,
	output logic [12:0]      nack_limit_ms_r,
	output logic             nack_overrun_r
);
	import mcbwp_pkg::*;

	function automatic logic [7:0] epl_last(input logic [3:0] code);
		case (code)
			4'h1: epl_last = 8'ha0;
			4'h2: epl_last = 8'ha1;
			4'h3: epl_last = 8'ha2;
			4'h4: epl_last = 8'ha3;
			4'h5: epl_last = 8'ha7;
			4'h6: epl_last = 8'hab;
			default: epl_last = PAGE_EPL_LAST;
		endcase
	endfunction

	function automatic logic [4:0] epl_count(input logic [3:0] code);
		case (code)
			4'h0: epl_count = 5'h00;
			4'h1, 4'h2, 4'h3, 4'h4: epl_count = {1'b0, code};
			4'h5: epl_count = 5'h08;
			4'h6: epl_count = 5'h0c;
			default: epl_count = 5'h10;
		endcase
	endfunction

	function automatic logic is_cmd_page(input logic [7:0] pg);
		is_cmd_page = (pg >= PAGE_CMD) && (pg <= PAGE_EPL_LAST);
	endfunction

	function automatic logic [12:0] nack_ms(input logic ind,
		input logic [4:0] cmd_f, input logic [6:0] max_f);
		logic [12:0] gen;
		gen = (max_f >= 7'd80) ? 13'h0000
			: NACK_BASE_MS - {6'h00, max_f};
		if (!ind)
			nack_ms = gen;
		else if (cmd_f == 5'h00)
			nack_ms = NACK_BASE_MS;
		else
			nack_ms = 13'(cmd_f * NACK_STEP_MS);
	endfunction

	// sanitised advertisement
	localparam logic [3:0] EPL_CODE = (P_EPL_CODE > 4'h7) ? 4'h7 : P_EPL_CODE;
	localparam logic [1:0] INSTANCES =
		(P_INSTANCES == 2'h3) ? INST_NONE : P_INSTANCES;
	localparam logic AUTOPAGE =
		P_AUTOPAGE && (epl_count(EPL_CODE) >= 5'h02);
	localparam logic [8:0] PAGE_ADV_MAX =
		9'(epl_count(EPL_CODE)) * 9'(ADV_STEPS_PER_PAGE) - 9'h001;
	localparam logic [7:0] MAX_WRITE = !AUTOPAGE
		? ((P_MAX_WRITE > ADV_MAX_NO_PAGING) ? ADV_MAX_NO_PAGING
			: P_MAX_WRITE)
		: ((9'(P_MAX_WRITE) > PAGE_ADV_MAX) ? PAGE_ADV_MAX[7:0]
			: P_MAX_WRITE);
	localparam logic [11:0] CMD_LIMIT =
		(12'(MAX_WRITE) + 12'h001) * BASE_WRITE_BYTES;
	localparam logic [7:0] LAST_PAGE = epl_last(EPL_CODE);
	localparam logic [7:0] BYTE_INST = {INSTANCES, P_BACKGROUND,
		AUTOPAGE, EPL_CODE};
	localparam logic [7:0] BYTE_TRIG = {P_PROC_OPT, 2'h0, P_CMD_NACK};
	localparam logic [7:0] BYTE_IND  = {P_NACK_IND, P_MAX_NACK};
	localparam logic [12:0] NACK_LIMIT =
		nack_ms(P_NACK_IND, P_CMD_NACK, P_MAX_NACK);

	mcbwp_state_t state_r, state_nxt;
	logic [7:0]  page_r;
	logic [7:0]  addr_r;
	logic        bank_r;
	logic [11:0] count_r;
	logic        cmd_seen_r;
	logic [1:0]  busy_r;
	logic        run_bank_r;
	logic [31:0] tick_cnt_r;
	logic [12:0] ms_cnt_r;
	logic        take_byte;
	logic [11:0] limit;
	logic        fire;
	logic        trig_ok;

	assign limit = is_cmd_page(page_r) ? CMD_LIMIT
		: BASE_WRITE_BYTES;
	assign take_byte = (state_r == ST_WRITE) && bus_byte_valid
		&& (count_r < limit);
	assign fire = P_PROC_OPT
		? ((state_r == ST_WRITE) && bus_stop && cmd_seen_r)
		: (take_byte && page_r == PAGE_CMD
			&& addr_r == ADDR_CMD_HI);
	assign trig_ok = fire && (INSTANCES != INST_NONE)
		&& !(bank_r && INSTANCES == INST_ONE)
		&& !busy_r[bank_r];

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (bus_start)
					state_nxt = ST_WRITE;
			end
			ST_WRITE: begin
				if (trig_ok)
					state_nxt = ST_CAPTURE;
				else if (bus_stop)
					state_nxt = ST_IDLE;
			end
			ST_CAPTURE: begin
				if (cmd_captured)
					state_nxt = P_BACKGROUND ? ST_IDLE
						: ST_EXECUTE;
			end
			ST_EXECUTE: begin
				if (cmd_done && cmd_done_bank == run_bank_r)
					state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// refusal flag follows the capture and execute states
	always_ff @(posedge clk) begin
		if (!resetn)
			bus_nack_r <= 1'b0;
		else
			bus_nack_r <= (state_nxt == ST_CAPTURE)
				|| (state_nxt == ST_EXECUTE);
	end

	// address pointer and length count
	always_ff @(posedge clk) begin
		if (!resetn) begin
			page_r     <= 8'h00;
			addr_r     <= 8'h00;
			bank_r     <= 1'b0;
			count_r    <= 12'h000;
			cmd_seen_r <= 1'b0;
		end else if (state_r == ST_IDLE && bus_start) begin
			page_r     <= bus_page;
			addr_r     <= bus_addr;
			bank_r     <= bus_bank;
			count_r    <= 12'h000;
			cmd_seen_r <= 1'b0;
		end else if (take_byte) begin
			count_r <= count_r + 12'h001;
			if (page_r == PAGE_CMD && (addr_r == ADDR_CMD_LO
				|| addr_r == ADDR_CMD_HI))
				cmd_seen_r <= 1'b1;
			if (addr_r == ADDR_UPPER_LAST && AUTOPAGE
				&& page_r >= PAGE_EPL_FIRST && page_r <= LAST_PAGE) begin
				addr_r <= ADDR_CMD_LO;
				page_r <= (page_r == LAST_PAGE) ? PAGE_EPL_FIRST
					: page_r + 8'h01;
			end else begin
				addr_r <= addr_r + 8'h01;
			end
		end
	end

	// store strobe; advertisement bytes are never written
	always_ff @(posedge clk) begin
		if (!resetn) begin
			mem_we_r   <= 1'b0;
			mem_bank_r <= 1'b0;
			mem_page_r <= 8'h00;
			mem_addr_r <= 8'h00;
			mem_data_r <= 8'h00;
		end else begin
			mem_we_r <= take_byte && !(page_r == PAGE_ADVERT
				&& addr_r >= ADDR_INST_ADV
				&& addr_r <= ADDR_NACK_IND);
			if (take_byte) begin
				mem_bank_r <= bank_r;
				mem_page_r <= page_r;
				mem_addr_r <= addr_r;
				mem_data_r <= bus_byte;
			end
		end
	end

	// command launch and per-bank busy
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cmd_start_r <= 1'b0;
			cmd_bank_r  <= 1'b0;
			run_bank_r  <= 1'b0;
			busy_r      <= 2'h0;
		end else begin
			cmd_start_r <= trig_ok;
			if (trig_ok) begin
				cmd_bank_r <= bank_r;
				run_bank_r <= bank_r;
			end
			for (int b = 0; b < 2; b++) begin
				if (trig_ok && bank_r == 1'(b))
					busy_r[b] <= 1'b1;
				else if (cmd_done && cmd_done_bank == 1'(b))
					busy_r[b] <= 1'b0;
			end
		end
	end

	// advertisement read port
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rd_data_r <= 8'h00;
			rd_hit_r  <= 1'b0;
		end else begin
			rd_hit_r  <= rd_req && rd_page == PAGE_ADVERT
				&& rd_addr >= ADDR_INST_ADV && rd_addr <= ADDR_NACK_IND;
			if (rd_req) begin
				case (rd_addr)
					ADDR_INST_ADV:  rd_data_r <= BYTE_INST;
					ADDR_MAX_WRITE: rd_data_r <= MAX_WRITE;
					ADDR_TRIG_NACK: rd_data_r <= BYTE_TRIG;
					ADDR_NACK_IND:  rd_data_r <= BYTE_IND;
					default:        rd_data_r <= 8'h00;
				endcase
			end
		end
	end

	// flash writes only while the bus is quiet
	always_ff @(posedge clk) begin
		if (!resetn)
			flash_gnt_r <= 1'b0;
		else
			flash_gnt_r <= flash_req && state_nxt != ST_WRITE
				&& !bus_start && state_r != ST_WRITE;
	end

	// refusal duration watch
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tick_cnt_r      <= 32'h0;
			ms_cnt_r        <= 13'h0000;
			nack_overrun_r  <= 1'b0;
			nack_limit_ms_r <= 13'h0000;
		end else begin
			nack_limit_ms_r <= NACK_LIMIT;
			if (trig_ok) begin
				tick_cnt_r     <= 32'h0;
				ms_cnt_r       <= 13'h0000;
				nack_overrun_r <= 1'b0;
			end else if (bus_nack_r) begin
				if (tick_cnt_r == 32'(P_CYCLES_PER_MS - 1)) begin
					tick_cnt_r <= 32'h0;
					if (ms_cnt_r != 13'h1fff)
						ms_cnt_r <= ms_cnt_r + 13'h0001;
				end else begin
					tick_cnt_r <= tick_cnt_r + 32'h1;
				end
				if (ms_cnt_r >= NACK_LIMIT)
					nack_overrun_r <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_nack_capture: assert property (cmd_start_r |-> bus_nack_r)
		else $error("refusal missing at command launch");
	chk_bg_release: assert property (state_r == ST_CAPTURE && cmd_captured
		&& P_BACKGROUND |=> !bus_nack_r)
		else $error("background release late");
	chk_fg_hold: assert property (state_r == ST_EXECUTE && !cmd_done
		|=> bus_nack_r)
		else $error("refusal dropped before completion");
	chk_len_limit: assert property (mem_we_r |-> $past(count_r) <
		(is_cmd_page($past(page_r)) ? CMD_LIMIT : BASE_WRITE_BYTES))
		else $error("byte stored beyond length limit");
	chk_page_wrap: assert property (take_byte && AUTOPAGE
		&& addr_r == ADDR_UPPER_LAST && page_r == LAST_PAGE
		|=> addr_r == ADDR_CMD_LO && page_r == PAGE_EPL_FIRST)
		else $error("page wrap wrong");
	chk_page_step: assert property (take_byte && AUTOPAGE
		&& addr_r == ADDR_UPPER_LAST && page_r >= PAGE_EPL_FIRST
		&& page_r < LAST_PAGE |=> page_r == $past(page_r) + 8'h01)
		else $error("page increment wrong");
	chk_adv_ro: assert property (mem_we_r |-> !(mem_page_r == PAGE_ADVERT
		&& mem_addr_r >= ADDR_INST_ADV && mem_addr_r <= ADDR_NACK_IND))
		else $error("advertisement written");
	chk_flash_quiet: assert property (flash_gnt_r |-> state_r != ST_WRITE)
		else $error("flash grant during host write");
	chk_bank_valid: assert property (cmd_start_r |-> INSTANCES == INST_TWO
		|| !cmd_bank_r)
		else $error("launch on unsupported bank");
	chk_adv_len: assert property (rd_hit_r && $past(rd_addr) == ADDR_MAX_WRITE
		|-> AUTOPAGE || rd_data_r <= ADV_MAX_NO_PAGING)
		else $error("advertised length too long");
	chk_limit_val: assert property ($past(resetn)
		|-> nack_limit_ms_r == NACK_LIMIT)
		else $error("refusal limit wrong");

	cov_launch: cover property (cmd_start_r ##[1:20] !bus_nack_r);
	cov_wrap: cover property (take_byte && addr_r == ADDR_UPPER_LAST);
	cov_discard: cover property (bus_byte_valid && state_r == ST_WRITE
		&& !take_byte);
endmodule // mcbwp_top

// >>> dv/mcbwp_cmd_engine.sv
// behavioural command engine facing the write path
// assumes one launch at a time, clocked by the management clock
`timescale 1ns/1ps
module mcbwp_cmd_engine #(
	parameter int P_FAST = 4,
	parameter int P_SLOW = 700
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic slow,
	input  wire logic cmd_start,
	input  wire logic cmd_bank,
	output logic      cmd_captured,
	output logic      cmd_done,
	output logic      cmd_done_bank
);
	logic busy;
	int   cnt;

	// capture early, finish promptly or slowly
	always @(posedge clk) begin
		cmd_captured <= 1'b0;
		cmd_done     <= 1'b0;
		if (!resetn) begin
			busy          <= 1'b0;
			cnt           <= 0;
			cmd_done_bank <= 1'b0;
		end else if (!busy && cmd_start) begin
			busy          <= 1'b1;
			cnt           <= 0;
			cmd_done_bank <= cmd_bank;
		end else if (busy) begin
			cnt <= cnt + 1;
			if (cnt == P_FAST)
				cmd_captured <= 1'b1;
			if (cnt == (slow ? P_SLOW : P_FAST * 5)) begin
				cmd_done <= 1'b1;
				busy     <= 1'b0;
			end
		end
	end
endmodule // mcbwp_cmd_engine

// >>> dv/module_command_block_write_path_test.sv
// bench for the command block write path, two configurations
// assumes the design's sanitising and the behavioural engine model
`timescale 1ns/1ps
module module_command_block_write_path_test;
	import mcbwp_pkg::*;
	logic        clk, resetn, bus_start, bus_bank, bus_byte_valid;
	logic        bus_stop, rd_req, cmd_captured, cmd_done, cmd_done_bank;
	logic        flash_req, eng_slow, a_seen, a_bank_seen, b_seen, gnt_bad;
	logic [7:0]  bus_page, bus_addr, bus_byte, rd_page, rd_addr;
	logic        a_nack, a_we, a_start, a_cbank, a_hit, a_gnt, a_ovr;
	logic        b_nack, b_we, b_start, b_ovr, b_hit, b_gnt, b_cbank;
	logic        a_mbank;
	logic [7:0]  a_page, a_addr, a_rd, b_rd, a_mdata;
	logic [12:0] a_lim, b_lim;
	logic [15:0] aq[$];
	int          b_cnt, miscompares, check_count;

	mcbwp_top #(.P_CYCLES_PER_MS(10)) u_mcbwp_top (
		.clk(clk), .resetn(resetn), .bus_start(bus_start),
		.bus_page(bus_page), .bus_bank(bus_bank), .bus_addr(bus_addr),
		.bus_byte_valid(bus_byte_valid), .bus_byte(bus_byte),
		.bus_stop(bus_stop), .rd_req(rd_req), .rd_page(rd_page),
		.rd_addr(rd_addr), .cmd_captured(cmd_captured),
		.cmd_done(cmd_done), .cmd_done_bank(cmd_done_bank),
		.flash_req(flash_req), .bus_nack_r(a_nack), .mem_we_r(a_we),
		.mem_bank_r(a_mbank), .mem_page_r(a_page), .mem_addr_r(a_addr),
		.mem_data_r(a_mdata), .cmd_start_r(a_start), .cmd_bank_r(a_cbank),
		.rd_data_r(a_rd), .rd_hit_r(a_hit), .flash_gnt_r(a_gnt),
		.nack_limit_ms_r(a_lim), .nack_overrun_r(a_ovr));

	// one instance, no background, byte-129 trigger, one payload page so no auto paging
	mcbwp_top #(.P_INSTANCES(2'h1), .P_BACKGROUND(1'b0), .P_EPL_CODE(4'h1),
		.P_PROC_OPT(1'b0), .P_NACK_IND(1'b0), .P_MAX_NACK(7'h14),
		.P_CYCLES_PER_MS(10)) u_mcbwp_top_b (
		.clk(clk), .resetn(resetn), .bus_start(bus_start),
		.bus_page(bus_page), .bus_bank(bus_bank), .bus_addr(bus_addr),
		.bus_byte_valid(bus_byte_valid), .bus_byte(bus_byte),
		.bus_stop(bus_stop), .rd_req(rd_req), .rd_page(rd_page),
		.rd_addr(rd_addr), .cmd_captured(cmd_captured),
		.cmd_done(cmd_done), .cmd_done_bank(cmd_done_bank),
		.flash_req(flash_req), .bus_nack_r(b_nack), .mem_we_r(b_we),
		.mem_bank_r(), .mem_page_r(), .mem_addr_r(), .mem_data_r(),
		.cmd_start_r(b_start), .cmd_bank_r(b_cbank), .rd_data_r(b_rd),
		.rd_hit_r(b_hit), .flash_gnt_r(b_gnt), .nack_limit_ms_r(b_lim),
		.nack_overrun_r(b_ovr));

	mcbwp_cmd_engine u_mcbwp_cmd_engine (
		.clk(clk), .resetn(resetn), .slow(eng_slow),
		.cmd_start(a_start), .cmd_bank(a_cbank),
		.cmd_captured(cmd_captured), .cmd_done(cmd_done),
		.cmd_done_bank(cmd_done_bank));

	// store log and sticky launch flags
	always @(posedge clk) begin
		if (a_we)
			aq.push_back({a_page, a_addr});
		if (b_we)
			b_cnt++;
		if (a_start) begin
			a_seen      <= 1'b1;
			a_bank_seen <= a_cbank;
		end
		if (b_start)
			b_seen <= 1'b1;
		if (a_we && a_gnt)
			gnt_bad <= 1'b1;
	end

	task automatic chk(input string nm, input logic [15:0] exp,
		input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] p, input logic [7:0] a,
		input int n, input logic bank);
		aq.delete();
		b_cnt = 0;
		@(posedge clk);
		bus_start <= 1'b1;
		bus_page  <= p;
		bus_addr  <= a;
		bus_bank  <= bank;
		@(posedge clk);
		bus_start <= 1'b0;
		for (int i = 0; i < n; i++) begin
			bus_byte_valid <= 1'b1;
			bus_byte       <= 8'(i);
			@(posedge clk);
		end
		bus_byte_valid <= 1'b0;
		bus_stop       <= 1'b1;
		@(posedge clk);
		bus_stop <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic rd(input logic [7:0] p, input logic [7:0] a);
		@(posedge clk);
		rd_req  <= 1'b1;
		rd_page <= p;
		rd_addr <= a;
		@(posedge clk);
		rd_req <= 1'b0;
		#1;
	endtask

	task automatic t_advert;
		logic [7:0] ea[4];
		logic [7:0] eb[4];
		ea = '{8'hb7, 8'hff, 8'h83, 8'h80};
		eb = '{8'h41, 8'h0f, 8'h03, 8'h14};
		chk("a limit ms", 13'h01e0, a_lim);
		chk("b limit ms", 13'h003c, b_lim);
		for (int i = 0; i < 4; i++) begin
			rd(PAGE_ADVERT, ADDR_INST_ADV + 8'(i));
			chk("a advert", ea[i], a_rd);
			chk("b advert", eb[i], b_rd);
			chk("a hit", 1'b1, a_hit);
			chk("b hit", 1'b1, b_hit);
		end
		rd(PAGE_ADVERT, 8'ha7);
		chk("unmapped data", 8'h00, a_rd);
		chk("unmapped hit", 1'b0, a_hit);
		wr(PAGE_ADVERT, ADDR_MAX_WRITE, 1, 1'b0);
		chk("advert store", 0, aq.size());
		rd(PAGE_ADVERT, ADDR_MAX_WRITE);
		chk("advert kept", 8'hff, a_rd);
	endtask

	task automatic t_limits;
		wr(8'h00, 8'h00, 10, 1'b0);
		chk("plain count", 8, aq.size());
		chk("store data", 8'h07, a_mdata);
		wr(PAGE_EPL_FIRST, ADDR_CMD_LO, 130, 1'b0);
		chk("long count", 130, aq.size());
		chk("next page", 16'ha180, aq[128]);
		chk("b clamp", 128, b_cnt);
		wr(PAGE_EPL_LAST, 8'hfe, 3, 1'b0);
		chk("wrap count", 3, aq.size());
		chk("last byte", 16'hafff, aq[1]);
		chk("page wrap", 16'ha080, aq[2]);
	endtask

	task automatic trig(input logic bank, input logic slow);
		int n;
		@(posedge clk);
		eng_slow  <= slow;
		flash_req <= 1'b1;
		a_seen  = 1'b0;
		b_seen  = 1'b0;
		gnt_bad = 1'b0;
		wr(PAGE_CMD, ADDR_CMD_LO, 3, bank);
		chk("a launch", 1'b1, a_seen);
		chk("b launch", !bank, b_seen);
		chk("launch bank", bank, a_bank_seen);
		chk("store bank", bank, a_mbank);
		chk("b bank", 1'b0, b_cbank);
		chk("a refuse", 1'b1, a_nack);
		chk("grant in write", 1'b0, gnt_bad);
		n = 0;
		while (!cmd_captured && n < 100) begin
			@(posedge clk);
			n++;
		end
		repeat (2) @(posedge clk);
		#1;
		chk("a answers", 1'b0, a_nack);
		chk("b refuses", !bank, b_nack);
		chk("flash grant", 1'b1, a_gnt);
		chk("b grant", 1'b1, b_gnt);
		rd(PAGE_ADVERT, ADDR_MAX_WRITE);
		chk("poll read", 8'hff, a_rd);
		a_seen = 1'b0;
		wr(PAGE_CMD, ADDR_CMD_LO, 3, bank);
		chk("busy refuse", 1'b0, a_seen);
		n = 0;
		while (!cmd_done && n < 1000) begin
			@(posedge clk);
			n++;
		end
		repeat (2) @(posedge clk);
		#1;
		chk("b released", 1'b0, b_nack);
		chk("b overrun", slow, b_ovr);
		chk("a overrun", 1'b0, a_ovr);
		@(posedge clk);
		flash_req <= 1'b0;
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		wrap_up;
	end

	initial begin
		{resetn, bus_start, bus_bank, bus_byte_valid, bus_stop} = '0;
		{rd_req, flash_req, eng_slow, a_seen, b_seen, gnt_bad} = '0;
		{bus_page, bus_addr, bus_byte, rd_page, rd_addr} = '0;
		a_bank_seen = 1'b0;
		miscompares = 0;
		check_count = 0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		t_advert;
		t_limits;
		trig(1'b1, 1'b0);
		trig(1'b0, 1'b1);
		wrap_up;
	end
endmodule // module_command_block_write_path_test
